// ### hw/ppi_intensity_top.sv
// Port intensity block: serial slave, two intensity registers, PWM ports.
// Serial pins come from outside and are synchronised; masterLevel is on clk_sys.
//
// Functional notes
// - Register 0x10: bits 7..4 port_one code, bits 3..0 port_zero code.
// - Register 0x11: upper nibble port_three code, lower nibble port_two code.
// - Code n from 0 to 14 gives a duty of n+1 sixteenths.
// - Code all ones gives full duty: static level, no switching.
// - Read/write bit 0 writes a register; bit 1 reads the stored pair back.
// - Master level zero stops the oscillator; all ports stay static.
`timescale 1ns/10ps
`include "ppi_defs.svh"

module ppi_intensity_top
   #(parameter logic [6:0] SLAVE_ADDR = `PPI_SLAVE_ADDR,
     parameter int         PRESCALE   = `PPI_PRESCALE)
   (
   input  wire logic               clk_sys,
   input  wire logic               nrst,
   input  wire logic               clkEn,
   input  wire logic               sclIn,
   input  wire logic               sdaIn,
   output logic                    sdaOut,
   output logic                    sdaOe,
   input  wire ppi_pkg::ppi_level_t masterLevel,
   output logic [3:0]              portOut,
   output logic [3:0]              portOe
   );
   import ppi_pkg::*;

   // Synchronisers reset to the idle-high bus level: no false edge after reset
   localparam ppi_slave_s SLAVE_RST = '{sclMeta: 1'b1, sclSync: 1'b1, sclLast: 1'b1,
                                        sdaMeta: 1'b1, sdaSync: 1'b1, sdaLast: 1'b1,
                                        st: PPI_IDLE, regLow: `PPI_INT_RESET,
                                        regHigh: `PPI_INT_RESET, default: '0};

   ppi_slave_s s;
   ppi_slave_s next_s;
   ppi_codes_s codes;
   logic       sclRise;
   logic       sclFall;
   logic       startSeen;
   logic       stopSeen;
   logic       byteDone;
   logic       wrStrobe;

   // Register contents at a pointer; unmapped pointers read zero
   function automatic logic [7:0] read_reg(input logic [7:0] ptr, input ppi_slave_s st);
      if (ptr == `PPI_REG_P10)
         read_reg = st.regLow;
      else if (ptr == `PPI_REG_P32)
         read_reg = st.regHigh;
      else
         read_reg = `PPI_REG_NONE;
   endfunction

   // Pointer auto-increment, wrapping inside the register pair
   function automatic logic [7:0] step_ptr(input logic [7:0] ptr);
      if (ptr == `PPI_REG_P32)
         step_ptr = `PPI_REG_P10;
      else
         step_ptr = ptr + 8'h01;
   endfunction

   // Bus events from the synchronised pins
   assign sclRise   = s.sclSync & ~s.sclLast;
   assign sclFall   = ~s.sclSync & s.sclLast;
   assign startSeen = s.sclSync & s.sclLast & s.sdaLast & ~s.sdaSync;
   assign stopSeen  = s.sclSync & s.sclLast & ~s.sdaLast & s.sdaSync;
   assign byteDone  = sclFall && s.bitCnt == 4'h8 && !startSeen && !stopSeen;
   assign wrStrobe  = byteDone && s.st == PPI_DATA && s.gotPtr;

   // Serial protocol and register updates
   always_comb
   begin
      logic       txLoad;
      logic [7:0] txByte;
      txLoad = 1'b0;
      txByte = read_reg(s.ptr, s);
      next_s = s;
      next_s.sclMeta = sclIn;
      next_s.sclSync = s.sclMeta;
      next_s.sclLast = s.sclSync;
      next_s.sdaMeta = sdaIn;
      next_s.sdaSync = s.sdaMeta;
      next_s.sdaLast = s.sdaSync;
      if (startSeen)
      begin
         next_s.st     = PPI_ADDR;
         next_s.bitCnt = 4'h0;
         next_s.gotPtr = 1'b0;
         next_s.sdaOe  = 1'b0;
      end
      else if (stopSeen)
      begin
         next_s.st    = PPI_IDLE;
         next_s.sdaOe = 1'b0;
      end
      else
      begin
         unique case (s.st)
            PPI_IDLE:
               next_s.bitCnt = 4'h0;
            PPI_ADDR, PPI_DATA:
               if (sclRise && s.bitCnt != 4'h8)
               begin
                  next_s.shreg  = {s.shreg[6:0], s.sdaSync};
                  next_s.bitCnt = s.bitCnt + 4'h1;
               end
               else if (byteDone)
               begin
                  next_s.bitCnt = 4'h0;
                  if (s.st == PPI_ADDR)
                  begin
                     if (s.shreg[7:1] == SLAVE_ADDR)
                     begin
                        next_s.isRead = s.shreg[0];
                        next_s.st     = PPI_ACK;
                        next_s.sdaOe  = 1'b1;
                     end
                     else
                        next_s.st = PPI_IDLE;
                  end
                  else
                  begin
                     next_s.st    = PPI_ACK;
                     next_s.sdaOe = 1'b1;
                     if (!s.gotPtr)
                     begin
                        next_s.ptr    = s.shreg;
                        next_s.gotPtr = 1'b1;
                     end
                     else
                     begin
                        if (s.ptr == `PPI_REG_P10)
                           next_s.regLow = s.shreg;
                        else if (s.ptr == `PPI_REG_P32)
                           next_s.regHigh = s.shreg;
                        next_s.ptr = step_ptr(s.ptr);
                     end
                  end
               end
            PPI_ACK:
               if (sclFall)
               begin
                  if (s.isRead)
                     txLoad = 1'b1;
                  else
                  begin
                     next_s.sdaOe = 1'b0;
                     next_s.st    = PPI_DATA;
                  end
               end
            PPI_TX:
               if (sclFall)
               begin
                  if (s.bitCnt == 4'h7)
                  begin
                     next_s.bitCnt = 4'h0;
                     next_s.sdaOe  = 1'b0;
                     next_s.st     = PPI_MACK;
                  end
                  else
                  begin
                     next_s.bitCnt = s.bitCnt + 4'h1;
                     next_s.shreg  = {s.shreg[6:0], 1'b0};
                     next_s.sdaOe  = ~s.shreg[6];
                  end
               end
            PPI_MACK:
               if (sclRise)
                  next_s.nack = s.sdaSync;
               else if (sclFall)
               begin
                  if (!s.nack)
                     txLoad = 1'b1;
                  else
                     next_s.st = PPI_IDLE;
               end
         endcase
      end
      // Read data loaded on the falling edge that ends an acknowledge
      if (txLoad)
      begin
         next_s.shreg  = txByte;
         next_s.sdaOe  = ~txByte[7];
         next_s.ptr    = step_ptr(s.ptr);
         next_s.bitCnt = 4'h0;
         next_s.st     = PPI_TX;
      end
   end

   // State register, frozen while clkEn is low
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         s <= SLAVE_RST;
      else if (clkEn)
         s <= next_s;
   end

   assign sdaOe  = s.sdaOe;
   assign sdaOut = s.sdaOut;
   assign codes  = {s.regHigh, s.regLow};

   // Duty generation for the four ports
   ppi_pwm_quad #(.PRESCALE(PRESCALE)) u_pwm
   (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .clkEn       (clkEn),
      .codes       (codes),
      .masterLevel (masterLevel),
      .portOut     (portOut),
      .portOe      (portOe)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_low_map;
      clkEn && wrStrobe && s.ptr == `PPI_REG_P10
         |=> codes.portOne == $past(s.shreg[7:4]) && codes.portZero == $past(s.shreg[3:0]);
   endproperty
   a_low_map: assert property (p_low_map) else $error("0x10 nibbles misplaced");

   property p_high_map;
      clkEn && wrStrobe && s.ptr == `PPI_REG_P32
         |=> codes.portThree == $past(s.shreg[7:4]) && codes.portTwo == $past(s.shreg[3:0]);
   endproperty
   a_high_map: assert property (p_high_map) else $error("0x11 nibbles misplaced");

   property p_read_back;
      clkEn && s.st == PPI_ACK && s.isRead && sclFall && !startSeen && !stopSeen
         && s.ptr == `PPI_REG_P10
         |=> s.st == PPI_TX && s.shreg == $past(s.regLow) && s.sdaOe == !$past(s.regLow[7]);
   endproperty
   a_read_back: assert property (p_read_back) else $error("read returned wrong data");

   property p_hold_codes;
      !wrStrobe |=> $stable(s.regLow) && $stable(s.regHigh);
   endproperty
   a_hold_codes: assert property (p_hold_codes) else $error("code changed without write");

   c_read: cover property (s.st == PPI_ACK && s.isRead ##[1:1000] s.st == PPI_MACK);
   c_write: cover property (wrStrobe && s.ptr == `PPI_REG_P32);

endmodule // ppi_intensity_top

// ### hw/ppi_defs.svh
// Offsets, reset values and counts for the port intensity block.
// Included by the design files; holds definitions only.
`ifndef PPI_DEFS_SVH
`define PPI_DEFS_SVH

// Register pointers
`define PPI_REG_P10     8'h10
`define PPI_REG_P32     8'h11
`define PPI_REG_NONE    8'h00

// Reset value of both intensity registers
`define PPI_INT_RESET   8'h00

// Code that asks for a static level
`define PPI_CODE_STATIC 4'hf

// Last slot of a sixteen-slot PWM cycle
`define PPI_SLOT_LAST   4'hf

// Serial slave address, arbitrary value
`define PPI_SLAVE_ADDR  7'h20

// System clock cycles per PWM slot
`define PPI_PRESCALE    16

`endif

// ### hw/ppi_pkg.sv
// Types shared by the port intensity block.
// Constants live in ppi_defs.svh.
package ppi_pkg;

   typedef logic [3:0] ppi_level_t;

   // Serial slave states, one-hot
   typedef enum logic [5:0] {
      PPI_IDLE = 6'h01,
      PPI_ADDR = 6'h02,
      PPI_DATA = 6'h04,
      PPI_ACK  = 6'h08,
      PPI_TX   = 6'h10,
      PPI_MACK = 6'h20
   } ppi_state_e;

   // Four intensity codes, upper register first
   typedef struct packed {
      ppi_level_t portThree;
      ppi_level_t portTwo;
      ppi_level_t portOne;
      ppi_level_t portZero;
   } ppi_codes_s;

   // Serial slave and register state
   typedef struct packed {
      logic       sclMeta;
      logic       sclSync;
      logic       sclLast;
      logic       sdaMeta;
      logic       sdaSync;
      logic       sdaLast;
      ppi_state_e st;
      logic [3:0] bitCnt;
      logic [7:0] shreg;
      logic       isRead;
      logic       gotPtr;
      logic       nack;
      logic [7:0] ptr;
      logic [7:0] regLow;
      logic [7:0] regHigh;
      logic       sdaOut;
      logic       sdaOe;
   } ppi_slave_s;

   // PWM generator state
   typedef struct packed {
      logic [7:0] presc;
      logic [3:0] slot;
      ppi_codes_s held;
      logic       masterOn;
      logic [3:0] oe;
      logic [3:0] low;
   } ppi_pwm_s;

endpackage

// ### hw/ppi_pwm_quad.sv
// Four-channel sixteen-slot PWM generator for the open-drain ports.
// Codes and master level come from logic on clk_sys.
`timescale 1ns/10ps
`include "ppi_defs.svh"

module ppi_pwm_quad
   #(parameter int PRESCALE = `PPI_PRESCALE)
   (
   input  wire logic          clk_sys,
   input  wire logic          nrst,
   input  wire logic          clkEn,
   input  wire ppi_pkg::ppi_codes_s codes,
   input  wire ppi_pkg::ppi_level_t masterLevel,
   output logic [3:0]         portOut,
   output logic [3:0]         portOe
   );
   import ppi_pkg::*;

   localparam logic [7:0] PRESC_LAST = 8'(PRESCALE - 1);

   ppi_pwm_s p;
   ppi_pwm_s next_p;

   // Elaboration check on the prescaler range
   if (PRESCALE < 1 || PRESCALE > 256)
   begin : g_bad_prescale
      $error("PRESCALE must lie in 1..256");
   end

   // Port sinks while slot is within code, or always for the static code
   function automatic logic duty_on(input ppi_level_t code, input logic [3:0] slot);
      duty_on = (code == `PPI_CODE_STATIC) || (slot <= code);
   endfunction

   // Slot timing, code hand-over at cycle wrap and output levels
   always_comb
   begin
      next_p = p;
      next_p.masterOn = (masterLevel != 4'h0);
      // Clear the slot on the turn-off edge too, so no stale slot shows while off
      if (!p.masterOn || !next_p.masterOn)
      begin
         next_p.presc = 8'h00;
         next_p.slot  = 4'h0;
         next_p.held  = codes;
      end
      else if (p.presc == PRESC_LAST)
      begin
         next_p.presc = 8'h00;
         next_p.slot  = p.slot + 4'h1;
         if (p.slot == `PPI_SLOT_LAST)
            next_p.held = codes;
      end
      else
         next_p.presc = p.presc + 8'h01;
      for (int i = 0; i < 4; i++)
         next_p.oe[i] = next_p.masterOn
                        && duty_on(next_p.held[i*4 +: 4], next_p.slot);
   end

   // State register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         p <= '0;
      else if (clkEn)
         p <= next_p;
   end

   assign portOe  = p.oe;
   assign portOut = p.low;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_duty_slots;
      p.masterOn && p.held.portZero != `PPI_CODE_STATIC
         |-> p.oe[0] == (p.slot <= p.held.portZero);
   endproperty
   a_duty_slots: assert property (p_duty_slots) else $error("duty slot mismatch");

   property p_static_full;
      (p.masterOn && p.held.portOne == `PPI_CODE_STATIC)[*3] |-> p.oe[1] && $stable(p.oe[1]);
   endproperty
   a_static_full: assert property (p_static_full) else $error("static code toggled");

   property p_master_off;
      !p.masterOn |-> p.oe == 4'h0 && p.slot == 4'h0;
   endproperty
   a_master_off: assert property (p_master_off) else $error("PWM ran with master off");

   property p_held_at_wrap;
      $changed(p.held) && p.masterOn && $past(p.masterOn)
         |-> p.slot == 4'h0 && $past(p.slot) == `PPI_SLOT_LAST;
   endproperty
   a_held_at_wrap: assert property (p_held_at_wrap) else $error("code taken mid cycle");

   c_wrap: cover property (p.masterOn && p.slot == `PPI_SLOT_LAST ##[1:300] p.slot == 4'h0);
   c_mid_duty: cover property (p.masterOn && p.held.portTwo == 4'h7 && p.oe[2] ##1 !p.oe[2]);

endmodule // ppi_pwm_quad

// ### testbench/ppi_host_model.sv
// Serial bus host model for the port intensity block.
// Assumes SDA is a wire-AND with a pull-up; 1 on sdaHost releases the line.
`timescale 1ns/10ps
`include "ppi_defs.svh"

module ppi_host_model
   #(parameter logic [6:0] ADDR = `PPI_SLAVE_ADDR)
   (
   input  wire logic clk_sys,
   input  wire logic sdaLine,
   output logic      sclIn,
   output logic      sdaHost
   );

   // Bus idle: both lines released high
   initial
   begin
      sclIn = 1'b1;
      sdaHost = 1'b1;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Start or repeated start: SDA falls while SCL high
   task automatic start;
      step(4); sdaHost <= 1'b1; step(4); sclIn <= 1'b1;
      step(6); sdaHost <= 1'b0; step(6); sclIn <= 1'b0;
   endtask

   // Stop: SDA rises while SCL high
   task automatic stop;
      step(4); sdaHost <= 1'b0; step(4); sclIn <= 1'b1;
      step(6); sdaHost <= 1'b1; step(6);
   endtask

   // One bit: data set mid low phase, sampled mid high phase
   task automatic bit_io(input logic b, output logic s);
      step(4); sdaHost <= b; step(4); sclIn <= 1'b1;
      step(3); @(negedge clk_sys); s = sdaLine; step(4); sclIn <= 1'b0;
   endtask

   // Byte out, MSB first; nak is the ninth bit as seen on the wire
   task automatic send_byte(input logic [7:0] d, output logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, nak);
   endtask

   // Byte in, then ack, or nack on the last byte
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, s);
   endtask

   // Pointer then n data bytes, upper byte of d first
   task automatic write_regs(input logic [7:0] ptr, input logic [15:0] d, input int n,
                             output logic nak);
      logic a;
      start;
      send_byte({ADDR, 1'b0}, nak);
      send_byte(ptr, a);
      for (int i = 0; i < n; i++) send_byte(d[15-8*i -: 8], a);
      stop;
   endtask

   // Pointer write, repeated start, n bytes read into d from the top
   task automatic read_regs(input logic [7:0] ptr, input int n, output logic [15:0] d);
      logic a;
      logic [7:0] b;
      d = 16'h0000;
      start;
      send_byte({ADDR, 1'b0}, a);
      send_byte(ptr, a);
      start;
      send_byte({ADDR, 1'b1}, a);
      for (int i = 0; i < n; i++)
      begin
         recv_byte(i == n - 1, b);
         d[15-8*i -: 8] = b;
      end
      stop;
   endtask

endmodule // ppi_host_model

// ### testbench/ppi_intensity_top_tb.sv
// Self-checking bench for the port intensity block.
// Runs the PWM with a prescale of 1; host model drives the serial pins.
`timescale 1ns/10ps
`include "ppi_defs.svh"

module ppi_intensity_top_tb;
   import ppi_pkg::*;

   localparam int PRESC = 1;
   logic        clk_sys, nrst, clkEn, sclIn, sdaHost, sdaIn, sdaOut, sdaOe, nak;
   ppi_level_t  masterLevel;
   logic [3:0]  portOut, portOe, frozen;
   logic [31:0] rng;
   logic [15:0] regs, got;
   int          err_total, n_tests;

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Open-drain wire with pull-up
   assign sdaIn = sdaHost & ~(sdaOe & ~sdaOut);

   ppi_intensity_top #(.PRESCALE(PRESC)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .masterLevel(masterLevel),
      .portOut(portOut), .portOe(portOe));

   ppi_host_model host (.clk_sys(clk_sys), .sdaLine(sdaIn), .sclIn(sclIn), .sdaHost(sdaHost));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // Slots on per cycle: code plus one, all sixteen for all ones
   function automatic logic [7:0] exp_on(input logic [3:0] c);
      return {4'h0, c} + 8'h01;
   endfunction

   task automatic close_out;
      if (err_total == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_duty(input logic [7:0] g, input logic [7:0] e);
      chk_byte(g, e);
   endtask

   // Count sink slots per port over one PWM cycle; r is {reg 0x11, reg 0x10}
   task automatic check_duty(input logic [15:0] r, input logic on);
      logic [7:0] cnt [4];
      cnt = '{default: 8'h00};
      repeat (40) @(posedge clk_sys);
      repeat (16 * PRESC)
      begin
         @(negedge clk_sys);
         for (int i = 0; i < 4; i++) cnt[i] += {7'h00, portOe[i]};
      end
      for (int i = 0; i < 4; i++)
         chk_duty(cnt[i], on ? exp_on(r[4*i +: 4]) : 8'h00);
      chk_byte({4'h0, portOut}, 8'h00);
      chk_byte({7'h00, sdaOut}, 8'h00);
      @(posedge clk_sys);
   endtask

   // Write both registers with auto-increment, read back, measure duty
   task automatic load_and_check(input logic [15:0] r);
      host.write_regs(8'h10, {r[7:0], r[15:8]}, 2, nak);
      chk_byte({7'h00, nak}, 8'h00);
      host.read_regs(8'h10, 2, got);
      chk_byte(got[15:8], r[7:0]);
      chk_byte(got[7:0], r[15:8]);
      host.read_regs(8'h11, 2, got);
      chk_byte(got[15:8], r[15:8]);
      check_duty(r, 1'b1);
   endtask

   // Hang guard
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      close_out;
   end

   // Main sequence
   initial
   begin
      err_total = 0;
      n_tests = 0;
      rng = 32'hed24;
      nrst = 1'b0;
      clkEn = 1'b1;
      masterLevel = 4'h0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      host.read_regs(8'h10, 2, got);
      chk_byte(got[15:8], `PPI_INT_RESET);
      chk_byte(got[7:0], `PPI_INT_RESET);
      masterLevel <= 4'h1;
      load_and_check(16'hf0e1);
      load_and_check(16'h0f7e);
      // Clock enable low must freeze the switching ports
      clkEn <= 1'b0;
      @(negedge clk_sys);
      frozen = portOe;
      repeat (20)
      begin
         @(negedge clk_sys);
         chk_byte({4'h0, portOe}, {4'h0, frozen});
      end
      @(posedge clk_sys);
      clkEn <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         rng = xs(rng);
         masterLevel <= rng[19:16] | 4'h1;
         load_and_check(rng[15:0]);
      end
      // Master off silences even static codes, codes kept
      load_and_check(16'hffff);
      masterLevel <= 4'h0;
      check_duty(16'hffff, 1'b0);
      masterLevel <= 4'h3;
      check_duty(16'hffff, 1'b1);
      // Wrong slave address gets no ack
      host.start;
      host.send_byte(8'h42, nak);
      host.stop;
      chk_byte({7'h00, nak}, 8'h01);
      // Unmapped pointer: ignored write, zero read
      host.write_regs(8'h20, 16'h5a00, 1, nak);
      host.read_regs(8'h20, 1, got);
      chk_byte(got[15:8], 8'h00);
      host.read_regs(8'h10, 2, got);
      chk_byte(got[15:8], 8'hff);
      // Mid-run reset clears the codes
      nrst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      host.read_regs(8'h10, 2, got);
      chk_byte(got[15:8], `PPI_INT_RESET);
      chk_byte(got[7:0], `PPI_INT_RESET);
      close_out;
   end

endmodule // ppi_intensity_top_tb
